//--- hw/flash_read_consts.svh
// constants of the serial flash read-command engine
// assumes inclusion by bare name from the design modules
`ifndef FLASH_READ_CONSTS_SVH
`define FLASH_READ_CONSTS_SVH

// read opcodes
`define FR_OP_FAST_READ 8'h0b
`define FR_OP_DDR_FAST_READ 8'h0d
`define FR_OP_DUAL_OUT 8'h3b
`define FR_OP_DUAL_IO 8'hbb
`define FR_OP_DDR_DUAL_IO 8'hbd
`define FR_OP_QUAD_OUT 8'h6b
`define FR_OP_QUAD_IO 8'heb

// dummy clocks per command
`define FR_DUMMY_FAST_READ 4'd8
`define FR_DUMMY_DDR_FAST_READ 4'd4
`define FR_DUMMY_DUAL_OUT 4'd8
`define FR_DUMMY_DUAL_IO_DEFAULT 4'd4
`define FR_DUMMY_DDR_DUAL_IO 4'd2
`define FR_DUMMY_QUAD_OUT 4'd8
`define FR_DUMMY_QUAD_IO 4'd6
`define FR_DUMMY_QPI_FAST_READ 4'd6
`define FR_DUMMY_QPI_DDR_FAST_READ 4'd3

// lane widths, bits per sample event
`define FR_WIDTH_1 3'd1
`define FR_WIDTH_2 3'd2
`define FR_WIDTH_4 3'd4

// field sizes and array bounds
`define FR_OPCODE_BITS 5'd8
`define FR_ADDRESS_BITS 5'd24
`define FR_LAST_ADDRESS 24'hffffff
`define FR_ZERO_ADDRESS 24'h000000

`endif

//--- hw/flash_read_engine.sv
// read-command engine of a serial flash: opcode, address, dummy, data phases
// assumes the host drives serialClock and chipSelectN; pins are synchronised here
// Function
// - raising chip select ends any read at once, even mid data.
// - fast read during internal erase, program or write is ignored.
// - double-rate single read: opcode single, address two bits per clock, dummy, data.
// - double-rate single read samples address and drives data on both edges.
// - any start address, advance per byte, wrap to zero after top.
// - double-rate single read rejected while internal cycle busy.
// - dual-output read: single-line address, eight dummy clocks, data on two lines.
// - dual in/out read: address, dummy and data two bits wide.
// - dual in/out read samples on rising, drives data on falling edges.
// - double-rate dual in/out: four bits per clock, two dummy clocks.
// - quad-output read: single-line address, eight dummy clocks, four-bit data.
// - quad-output read latches on rising, shifts data on falling edges.
// - quad in/out read: four-bit address, six dummy clocks, four-bit data.
// - quad in/out read samples nibbles rising, drives nibbles falling.
// - fast read and double-rate fast read accepted in four-line mode.
// - standard fast read: rising-edge input, eight dummy clocks, falling-edge data.
// - quad enable set disables write-protect and hold on lines two and three.
`timescale 1ns/10ps
`include "flash_read_consts.svh"
module flash_read_engine #(
  parameter logic [3:0] DUAL_IO_DUMMY_CLOCKS = `FR_DUMMY_DUAL_IO_DEFAULT
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic serialClock,
  input wire logic chipSelectN,
  input wire logic io_line_0_in,
  output logic io_line_0_out,
  output logic io_line_0_oe,
  input wire logic io_line_1_in,
  output logic io_line_1_out,
  output logic io_line_1_oe,
  input wire logic io_line_2_in,
  output logic io_line_2_out,
  output logic io_line_2_oe,
  input wire logic io_line_3_in,
  output logic io_line_3_out,
  output logic io_line_3_oe,
  input wire logic quad_enable_bit,
  input wire logic fourLineMode,
  input wire logic internalBusy,
  output logic [23:0] memAddress,
  input wire logic [7:0] memData,
  output logic writeProtectActive,
  output logic holdActive
);
  import flash_read_pkg::*;

  // ----------------------------------------------------------------
  // decode functions
  // ----------------------------------------------------------------
  function automatic command_config_type decodeCommand(input logic [7:0] op, input logic qpi);
    command_config_type c;
    c = '0;
    if (qpi) begin
      if (op == `FR_OP_FAST_READ) begin
        c = '{1'b1, 1'b0, `FR_WIDTH_4, `FR_WIDTH_4, `FR_DUMMY_QPI_FAST_READ};
      end else if (op == `FR_OP_DDR_FAST_READ) begin
        c = '{1'b1, 1'b1, `FR_WIDTH_4, `FR_WIDTH_4, `FR_DUMMY_QPI_DDR_FAST_READ};
      end
    end else if (op == `FR_OP_FAST_READ) begin
      c = '{1'b1, 1'b0, `FR_WIDTH_1, `FR_WIDTH_1, `FR_DUMMY_FAST_READ};
    end else if (op == `FR_OP_DDR_FAST_READ) begin
      c = '{1'b1, 1'b1, `FR_WIDTH_1, `FR_WIDTH_1, `FR_DUMMY_DDR_FAST_READ};
    end else if (op == `FR_OP_DUAL_OUT) begin
      c = '{1'b1, 1'b0, `FR_WIDTH_1, `FR_WIDTH_2, `FR_DUMMY_DUAL_OUT};
    end else if (op == `FR_OP_DUAL_IO) begin
      c = '{1'b1, 1'b0, `FR_WIDTH_2, `FR_WIDTH_2, DUAL_IO_DUMMY_CLOCKS};
    end else if (op == `FR_OP_DDR_DUAL_IO) begin
      c = '{1'b1, 1'b1, `FR_WIDTH_2, `FR_WIDTH_2, `FR_DUMMY_DDR_DUAL_IO};
    end else if (op == `FR_OP_QUAD_OUT) begin
      c = '{1'b1, 1'b0, `FR_WIDTH_1, `FR_WIDTH_4, `FR_DUMMY_QUAD_OUT};
    end else if (op == `FR_OP_QUAD_IO) begin
      c = '{1'b1, 1'b0, `FR_WIDTH_4, `FR_WIDTH_4, `FR_DUMMY_QUAD_IO};
    end
    return c;
  endfunction

  // msb-first shift of one sample group into the address
  function automatic logic [23:0] shiftAddress(input logic [2:0] w, input logic [23:0] a, input logic [3:0] io);
    logic [23:0] r;
    r = {a[22:0], io[0]};
    if (w == `FR_WIDTH_2) begin
      r = {a[21:0], io[1:0]};
    end else if (w == `FR_WIDTH_4) begin
      r = {a[19:0], io};
    end
    return r;
  endfunction

  // next output group: {outBits, dataShift, groupCount, advance}
  function automatic logic [15:0] nextGroup(input logic [2:0] w, input logic [7:0] shift,
                                            input logic [2:0] cnt, input logic [7:0] fresh);
    logic [7:0] b;
    logic [3:0] o;
    logic [2:0] last;
    b = (cnt == 3'd0) ? fresh : shift;
    o = {2'b00, b[7], 1'b0};
    last = 3'd7;
    if (w == `FR_WIDTH_2) begin
      o = {2'b00, b[7:6]};
      last = 3'd3;
    end else if (w == `FR_WIDTH_4) begin
      o = b[7:4];
      last = 3'd1;
    end
    return {o, 8'(b << w), (cnt == 3'd0) ? last : 3'(cnt - 3'd1), cnt == 3'd0};
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [5:0] pinsSync;
  logic sclkSync;
  logic csHigh;
  logic [3:0] ioSync;

  pin_sync #(.WIDTH(6)) u_pin_sync (
    .ref_clk(ref_clk),
    .reset(reset),
    .pinIn({serialClock, chipSelectN, io_line_3_in, io_line_2_in, io_line_1_in, io_line_0_in}),
    .pinSync(pinsSync)
  );

  assign sclkSync = pinsSync[5];
  assign csHigh = pinsSync[4];
  assign ioSync = pinsSync[3:0];

  // ----------------------------------------------------------------
  // engine state
  // ----------------------------------------------------------------
  localparam engine_state_type ENGINE_RESET = '{state: IDLE, default: '0};

  engine_state_type st_reg;
  engine_state_type st_next;
  command_config_type decoded;
  logic riseEv;
  logic fallEv;
  logic quadPhase;
  logic pinFunctionsOn;
  logic counterLoad;
  logic counterAdvance;
  logic [15:0] group;

  assign riseEv = sclkSync & ~st_reg.sclkLast;
  assign fallEv = ~sclkSync & st_reg.sclkLast;
  assign quadPhase = (st_reg.state == ADDRESS || st_reg.state == DUMMY || st_reg.state == DATA) &&
                     (st_reg.cfg.addrWidth == `FR_WIDTH_4 || st_reg.cfg.dataWidth == `FR_WIDTH_4);
  // quad enable frees lines two and three
  assign pinFunctionsOn = !quad_enable_bit && !fourLineMode && !quadPhase;
  assign writeProtectActive = pinFunctionsOn && !ioSync[2];
  assign holdActive = pinFunctionsOn && !ioSync[3] && !csHigh;

  always_comb begin
    st_next = st_reg;
    st_next.sclkLast = sclkSync;
    counterLoad = 1'b0;
    counterAdvance = 1'b0;
    decoded = '0;
    group = nextGroup(st_reg.cfg.dataWidth, st_reg.dataShift, st_reg.groupCount, memData);
    case (st_reg.state)
      IDLE: begin
        if (!csHigh) begin
          st_next.state = OPCODE;
          st_next.bitCount = '0;
          st_next.opcode = '0;
        end
      end
      OPCODE: begin
        if (riseEv && !holdActive) begin
          st_next.opcode = fourLineMode ? {st_reg.opcode[3:0], ioSync} : {st_reg.opcode[6:0], ioSync[0]};
          st_next.bitCount = st_reg.bitCount + (fourLineMode ? 5'd4 : 5'd1);
          if (st_next.bitCount == `FR_OPCODE_BITS) begin
            decoded = decodeCommand(st_next.opcode, fourLineMode);
            st_next.cfg = decoded;
            st_next.bitCount = '0;
            if (!decoded.valid || internalBusy) begin
              st_next.state = IGNORE;
            end else begin
              st_next.state = ADDRESS;
            end
          end
        end
      end
      ADDRESS: begin
        if (!holdActive && (riseEv || (fallEv && st_reg.cfg.ddr && st_reg.bitCount != 5'd0))) begin
          st_next.addrShift = shiftAddress(st_reg.cfg.addrWidth, st_reg.addrShift, ioSync);
          st_next.bitCount = st_reg.bitCount + {2'b00, st_reg.cfg.addrWidth};
          if (st_next.bitCount == `FR_ADDRESS_BITS) begin
            counterLoad = 1'b1;
            st_next.state = DUMMY;
            st_next.dummyCount = '0;
            st_next.groupCount = '0;
          end
        end
      end
      DUMMY: begin
        // dummy input values are never looked at
        if (!holdActive && ((riseEv && !st_reg.cfg.ddr) || (fallEv && st_reg.cfg.ddr))) begin
          st_next.dummyCount = st_reg.dummyCount + 4'd1;
          if (st_next.dummyCount == st_reg.cfg.dummyClocks) begin
            st_next.state = DATA;
            // double rate: first group leaves on the last dummy falling edge
            if (st_reg.cfg.ddr) begin
              {st_next.outBits, st_next.dataShift, st_next.groupCount, counterAdvance} = group;
            end
          end
        end
      end
      DATA: begin
        if (!holdActive && (fallEv || (riseEv && st_reg.cfg.ddr))) begin
          {st_next.outBits, st_next.dataShift, st_next.groupCount, counterAdvance} = group;
        end
      end
      default: begin
      end
    endcase
    if (csHigh) begin
      st_next.state = IDLE;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      st_reg <= ENGINE_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  read_address_counter u_read_address_counter (
    .ref_clk(ref_clk),
    .reset(reset),
    .load(counterLoad),
    .loadValue(st_next.addrShift),
    .advance(counterAdvance),
    .address(memAddress)
  );

  // ----------------------------------------------------------------
  // pin drivers
  // ----------------------------------------------------------------
  logic driving;
  logic [3:0] laneEnable;

  assign driving = (st_reg.state == DATA) && !csHigh && !holdActive;
  assign laneEnable = (st_reg.cfg.dataWidth == `FR_WIDTH_4) ? 4'hf :
                      (st_reg.cfg.dataWidth == `FR_WIDTH_2) ? 4'h3 : 4'h2;
  assign {io_line_3_oe, io_line_2_oe, io_line_1_oe, io_line_0_oe} = driving ? laneEnable : 4'h0;
  assign {io_line_3_out, io_line_2_out, io_line_1_out, io_line_0_out} = st_reg.outBits;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sequence s_opcode_done;
    st_reg.state == OPCODE && st_next.state != OPCODE && !csHigh;
  endsequence

  sequence s_address_done;
    st_reg.state == ADDRESS && st_next.state == DUMMY;
  endsequence

  property p_cs_abort;
    @(posedge ref_clk) disable iff (reset)
    csHigh |=> st_reg.state == IDLE ##0 {io_line_3_oe, io_line_2_oe, io_line_1_oe, io_line_0_oe} == 4'h0;
  endproperty
  a_cs_abort: assert property (p_cs_abort) else $error("read not ended by chip select");

  property p_busy_reject;
    @(posedge ref_clk) disable iff (reset)
    (s_opcode_done and internalBusy) |=> st_reg.state == IGNORE ##1 (st_reg.state == IGNORE || st_reg.state == IDLE);
  endproperty
  a_busy_reject: assert property (p_busy_reject) else $error("read accepted while busy");

  property p_unknown_idle;
    @(posedge ref_clk) disable iff (reset)
    (s_opcode_done and !decoded.valid) |=> st_reg.state == IGNORE;
  endproperty
  a_unknown_idle: assert property (p_unknown_idle) else $error("unknown opcode not ignored");

  property p_address_bits;
    @(posedge ref_clk) disable iff (reset)
    s_address_done |-> st_next.bitCount == 5'd24 ##1 memAddress == $past(st_next.addrShift);
  endproperty
  a_address_bits: assert property (p_address_bits) else $error("address not 24 bits or not loaded");

  property p_ddr_both_edges;
    @(posedge ref_clk) disable iff (reset)
    (st_reg.state == DATA && st_reg.cfg.ddr && riseEv && !csHigh && !holdActive)
      |=> st_reg.groupCount != $past(st_reg.groupCount);
  endproperty
  a_ddr_both_edges: assert property (p_ddr_both_edges) else $error("no data on rising edge");

  property p_sdr_falling_only;
    @(posedge ref_clk) disable iff (reset)
    (st_reg.state == DATA && !st_reg.cfg.ddr && riseEv) |=> $stable(st_reg.outBits);
  endproperty
  a_sdr_falling_only: assert property (p_sdr_falling_only) else $error("data moved on rising edge");

  property p_address_wrap;
    @(posedge ref_clk) disable iff (reset)
    (counterAdvance && !counterLoad && memAddress == `FR_LAST_ADDRESS) |=> memAddress == `FR_ZERO_ADDRESS;
  endproperty
  a_address_wrap: assert property (p_address_wrap) else $error("address did not wrap");

  property p_dual_lanes;
    @(posedge ref_clk) disable iff (reset)
    (driving && st_reg.cfg.dataWidth == `FR_WIDTH_2) |-> {io_line_1_oe, io_line_0_oe, io_line_2_oe} == 3'b110;
  endproperty
  a_dual_lanes: assert property (p_dual_lanes) else $error("dual data lanes wrong");

  property p_quad_enable;
    @(posedge ref_clk) disable iff (reset)
    quad_enable_bit |-> !holdActive && !writeProtectActive;
  endproperty
  a_quad_enable: assert property (p_quad_enable) else $error("pin functions active with quad enable");

endmodule

//--- hw/flash_read_pkg.sv
// types of the serial flash read-command engine
// assumes flash_read_consts.svh is on the include path
package flash_read_pkg;

  // gray codes along idle, opcode, address, dummy, data
  typedef enum logic [2:0] {
    IDLE = 3'b000,
    OPCODE = 3'b001,
    ADDRESS = 3'b011,
    DUMMY = 3'b010,
    DATA = 3'b110,
    IGNORE = 3'b111
  } engine_phase_type;

  typedef struct packed {
    logic valid;
    logic ddr;
    logic [2:0] addrWidth;
    logic [2:0] dataWidth;
    logic [3:0] dummyClocks;
  } command_config_type;

  typedef struct packed {
    engine_phase_type state;
    logic [7:0] opcode;
    command_config_type cfg;
    logic [4:0] bitCount;
    logic [3:0] dummyCount;
    logic [23:0] addrShift;
    logic [7:0] dataShift;
    logic [2:0] groupCount;
    logic [3:0] outBits;
    logic sclkLast;
  } engine_state_type;

endpackage

//--- hw/pin_sync.sv
// two-flop synchroniser for pins arriving from outside the ref_clk domain
// assumes inputs are asynchronous levels; stage one is read by stage two only
`timescale 1ns/10ps
module pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] pinIn,
  output logic [WIDTH-1:0] pinSync
);

  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } sync_state_type;

  sync_state_type st_reg;
  sync_state_type st_next;

  always_comb begin
    st_next.stage1 = pinIn;
    st_next.stage2 = st_reg.stage1;
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      // start at the pin levels, so no false edge follows reset
      st_reg <= {pinIn, pinIn};
    end else begin
      st_reg <= st_next;
    end
  end

  assign pinSync = st_reg.stage2;

endmodule

//--- hw/read_address_counter.sv
// read address counter: loads a start address, advances per data byte
// assumes load and advance come from logic on ref_clk
`timescale 1ns/10ps
`include "flash_read_consts.svh"
module read_address_counter (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic load,
  input wire logic [23:0] loadValue,
  input wire logic advance,
  output logic [23:0] address
);

  typedef struct packed {
    logic [23:0] address;
  } counter_state_type;

  counter_state_type st_reg;
  counter_state_type st_next;

  always_comb begin
    st_next = st_reg;
    if (load) begin
      st_next.address = loadValue;
    end else if (advance) begin
      if (st_reg.address == `FR_LAST_ADDRESS) begin
        st_next.address = `FR_ZERO_ADDRESS;
      end else begin
        st_next.address = st_reg.address + 24'h000001;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign address = st_reg.address;

endmodule

//--- tb/flash_host_model.sv
// host side of the serial read link: select, serial clock and line drivers
// assumes the bench resolves each line from both parties' enables
`timescale 1ns/10ps
module flash_host_model (
  input wire logic ref_clk,
  input wire logic [3:0] lineLevel,
  input wire logic [3:0] deviceOe,
  output logic serialClock,
  output logic chipSelectN,
  output logic [3:0] hostValue,
  output logic [3:0] hostOe
);
  logic [3:0] seenLevel;
  logic [3:0] seenOe;
  initial begin
    serialClock = 1'b0;
    chipSelectN = 1'b1;
    hostValue = 4'h0;
    hostOe = 4'h0;
  end
  // ------------------------------------------------------------
  // pin tasks
  // ------------------------------------------------------------
  // one half period: set lines, sample just before the edge, toggle
  task automatic half(input logic [3:0] val, input logic [3:0] drv);
    @(posedge ref_clk);
    hostValue <= val;
    hostOe <= drv;
    repeat (8) @(posedge ref_clk);
    seenLevel = lineLevel;
    seenOe = deviceOe;
    serialClock <= ~serialClock;
    repeat (7) @(posedge ref_clk);
  endtask
  task automatic pins(input logic cs, input logic [3:0] val, input logic [3:0] drv);
    @(posedge ref_clk);
    chipSelectN <= cs;
    hostValue <= val;
    hostOe <= drv;
  endtask
  // ------------------------------------------------------------
  // one read command, data groups collected msb first
  // ------------------------------------------------------------
  task automatic transfer(input logic [7:0] op, input logic qpi, input int aw, input int dw, input logic ddr,
                          input int dummy, input logic [23:0] addr, input int groups, input logic [3:0] hi,
                          output logic [127:0] got, output int oeCount);
    logic [23:0] sh;
    logic [3:0] am;
    logic [3:0] dm;
    got = '0;
    oeCount = 0;
    sh = addr;
    am = 4'((1 << aw) - 1);
    dm = (dw == 1) ? 4'h2 : 4'((1 << dw) - 1);
    pins(1'b0, hi, hi);
    repeat (8) @(posedge ref_clk);
    for (int i = 0; i < (qpi ? 2 : 8); i++) begin
      repeat (2) half(qpi ? op[7 - 4 * i -: 4] : (hi | 4'(op[7 - i])), qpi ? 4'hf : (hi | 4'h1));
    end
    for (int i = 0; i < 24 / aw; i++) begin
      repeat (ddr ? 1 : 2) half(hi | 4'(sh[23 -: 4] >> (4 - aw)), hi | am);
      sh = sh << aw;
    end
    repeat (2 * dummy) half(hi, hi);
    for (int i = 0; i < (ddr ? groups : 2 * groups); i++) begin
      half(hi & ~dm, hi & ~dm);
      if (ddr || i % 2 == 0) begin
        got = (got << dw) | 128'((dw == 1) ? 4'(seenLevel[1]) : (seenLevel & dm));
        oeCount += (seenOe === dm) ? 1 : ((seenOe === 4'h0) ? 0 : 1000);
      end
    end
    pins(1'b1, 4'h0, 4'h0);
  endtask
endmodule

//--- tb/flash_read_engine_test.sv
// self-checking bench of the read-command engine against a host model
// assumes a 200 MHz ref_clk and a behavioural array image on memData
`timescale 1ns/10ps
module flash_read_engine_test;
  localparam int DUAL_DUMMY = 5;
  logic ref_clk, reset, quadEnable, fourLine, busy, serialClock, chipSelectN;
  logic writeProtectActive, holdActive;
  logic [7:0] memData;
  logic [23:0] memAddress;
  logic [3:0] devOut, devOe, hostValue, hostOe, lineLevel, junk;
  logic [127:0] got;
  int num_errors, checks, seed, oeCount;
  logic [7:0] ops [9] = '{8'h0b, 8'h0d, 8'h3b, 8'hbb, 8'hbd, 8'h6b, 8'heb, 8'h0b, 8'h0d};
  int aws [9] = '{1, 1, 1, 2, 2, 1, 4, 4, 4};
  int dws [9] = '{1, 1, 2, 2, 2, 4, 4, 4, 4};
  int dums [9] = '{8, 4, 8, DUAL_DUMMY, 2, 8, 6, 6, 3};
  logic [8:0] ddrs = 9'b100010010;
  // ------------------------------------------------------------
  // design, host and wire levels
  // ------------------------------------------------------------
  // dummy count off default
  flash_read_engine #(.DUAL_IO_DUMMY_CLOCKS(4'(DUAL_DUMMY))) flash_read_engine_inst (
    .ref_clk(ref_clk), .reset(reset), .serialClock(serialClock), .chipSelectN(chipSelectN),
    .io_line_0_in(lineLevel[0]), .io_line_0_out(devOut[0]), .io_line_0_oe(devOe[0]),
    .io_line_1_in(lineLevel[1]), .io_line_1_out(devOut[1]), .io_line_1_oe(devOe[1]),
    .io_line_2_in(lineLevel[2]), .io_line_2_out(devOut[2]), .io_line_2_oe(devOe[2]),
    .io_line_3_in(lineLevel[3]), .io_line_3_out(devOut[3]), .io_line_3_oe(devOe[3]),
    .quad_enable_bit(quadEnable), .fourLineMode(fourLine), .internalBusy(busy), .memAddress(memAddress),
    .memData(memData), .writeProtectActive(writeProtectActive), .holdActive(holdActive));
  flash_host_model flash_host_model_inst (.ref_clk(ref_clk), .lineLevel(lineLevel), .deviceOe(devOe),
    .serialClock(serialClock), .chipSelectN(chipSelectN), .hostValue(hostValue), .hostOe(hostOe));
  // undriven lines show a pattern that changes every cycle
  assign lineLevel = (devOe & devOut) | (~devOe & hostOe & hostValue) | (~devOe & ~hostOe & junk);
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      junk <= 4'h5;
      memData <= 8'h00;
    end else begin
      junk <= ~junk;
      memData <= mem_byte(memAddress);
    end
  end
  // ------------------------------------------------------------
  // expectations, comparison and verdict
  // ------------------------------------------------------------
  function automatic logic [7:0] mem_byte(input logic [23:0] a);
    return a[7:0] ^ a[15:8] ^ a[23:16] ^ 8'h5a;
  endfunction
  function automatic logic [127:0] expect_bits(input logic [23:0] a, input int nbits);
    logic [127:0] r;
    logic [7:0] b;
    r = '0;
    for (int i = 0; i < nbits; i++) begin
      b = mem_byte(a + 24'(i / 8));
      r = {r[126:0], b[7 - i % 8]};
    end
    return r;
  endfunction
  task automatic compare(input logic [127:0] actual, input logic [127:0] expected, input string what);
    checks++;
    if (actual !== expected) begin
      num_errors++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, actual, expected);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // one command with mode inputs, then data, oe and release checks
  task automatic run(input int k, input logic [7:0] op, input logic [23:0] addr, input int groups,
                     input logic qe, input logic bz, input logic ok);
    @(posedge ref_clk);
    quadEnable <= qe;
    fourLine <= (k > 6);
    busy <= bz;
    flash_host_model_inst.transfer(op, k > 6, aws[k], dws[k], ddrs[k], dums[k], addr, groups,
                                   qe ? 4'h0 : 4'hc, got, oeCount);
    repeat (6) @(posedge ref_clk);
    compare(128'(devOe), 128'(0), "oe after select high");
    compare(128'(oeCount), 128'(ok ? groups : 0), "driven groups");
    if (ok && dws[k] == 1) begin
      compare(got, expect_bits(addr, groups), "single data");
    end
    if (ok && dws[k] == 2) begin
      compare(got, expect_bits(addr, groups * 2), "dual data");
    end
    if (ok && dws[k] == 4) begin
      compare(got, expect_bits(addr, groups * 4), "quad data");
    end
    busy <= 1'b0;
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  initial begin
    seed = 60590;
    num_errors = 0;
    checks = 0;
    reset = 1'b1;
    quadEnable = 1'b0;
    fourLine = 1'b0;
    busy = 1'b0;
    repeat (12) @(posedge ref_clk);
    reset <= 1'b0;
    repeat (4) @(posedge ref_clk);
    // every command, random start then the top address to wrap
    for (int pass = 0; pass < 2; pass++) begin
      for (int k = 0; k < 9; k++) begin
        run(k, ops[k], pass ? 24'hffffff : 24'($random(seed)), 16 / dws[k], (k >= 6) | 1'($random(seed)),
            1'b0, 1'b1);
      end
    end
    run(0, 8'h0b, 24'h000123, 3, 1'b0, 1'b0, 1'b1);
    run(0, 8'h0b, 24'($random(seed)), 8, 1'b1, 1'b1, 1'b0);
    run(1, 8'h0d, 24'($random(seed)), 8, 1'b0, 1'b1, 1'b0);
    run(0, 8'h5c, 24'($random(seed)), 8, 1'b0, 1'b0, 1'b0);
    run(7, 8'h3b, 24'($random(seed)), 2, 1'b1, 1'b0, 1'b0);
    run(4, 8'hbd, 24'($random(seed)), 8, 1'b0, 1'b0, 1'b1);
    // write-protect and hold pins with and without quad enable
    fourLine <= 1'b0;
    quadEnable <= 1'b0;
    flash_host_model_inst.pins(1'b0, 4'h0, 4'hc);
    repeat (6) @(posedge ref_clk);
    compare(128'({writeProtectActive, holdActive}), 128'(2'b11), "pin functions, quad enable clear");
    quadEnable <= 1'b1;
    repeat (3) @(posedge ref_clk);
    compare(128'({writeProtectActive, holdActive}), 128'(2'b00), "pin functions, quad enable set");
    flash_host_model_inst.pins(1'b1, 4'h0, 4'h0);
    repeat (6) @(posedge ref_clk);
    tally_and_finish();
  end
  initial begin
    repeat (100000) @(posedge ref_clk);
    num_errors++;
    tally_and_finish();
  end
endmodule
